// *** core/ekwdt_pkg.sv ***
/*
 * Constants, timing counts and pin carrier type for the edge-kicked watchdog.
 * Assumes a single 20 MHz system clock; the typical times and the kick minimum are converted to cycles here.
 */
`default_nettype none

package ekwdt_pkg;

	// System clock
	localparam int unsigned CLK_HZ         = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;

	// Timeout period, in milliseconds (min, typ, max)
	localparam int unsigned TIMEOUT_MIN_MS = 1120;
	localparam int unsigned TIMEOUT_TYP_MS = 1600;
	localparam int unsigned TIMEOUT_MAX_MS = 2400;
	localparam int unsigned TIMEOUT_CYC    = TIMEOUT_TYP_MS * CYC_PER_MS;

	// Fault pulse period, in milliseconds (min, typ, max)
	localparam int unsigned PULSE_MIN_MS   = 140;
	localparam int unsigned PULSE_TYP_MS   = 200;
	localparam int unsigned PULSE_MAX_MS   = 280;
	localparam int unsigned PULSE_CYC      = PULSE_TYP_MS * CYC_PER_MS;

	// Shortest kick level that must be seen; least time, so round up
	localparam int unsigned KICK_MIN_NS    = 50;
	localparam int unsigned KICK_MIN_RAW   = (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned KICK_MIN_CYC   = (KICK_MIN_RAW < 1) ? 1 : KICK_MIN_RAW;

	// Weak driver is high for the last eighth of the timeout period
	localparam int unsigned DRIVE_HI_DIV   = 8;

	// Counter width and reset values
	localparam int unsigned CNT_W          = 32;
	localparam logic        FAULT_N_RST    = 1'b0;
	localparam logic        DRIVE_RST      = 1'b0;
	localparam logic        OE_N_RST       = 1'b1;

	// Kick pin carrier: weak drive level and its enable (low while driving)
	typedef struct packed {
		logic drive;
		logic oe_n;
	} ekwdt_kick_pin_type;

	// Controller states
	typedef enum logic [2:0] {
		ST_LOCK  = 3'b001,
		ST_PULSE = 3'b010,
		ST_RUN   = 3'b100
	} ekwdt_state_type;

endpackage

`default_nettype wire

// *** core/ekwdt_top.sv ***
/*
 * Edge-kicked watchdog timer: timeout counter, fault pulse timer, power-good
 * lockout handling and the weak self-servicing driver on the kick pin.
 * Assumes kick_input and power_good_lockout are synchronous to clk_sys, and
 * that the bench resolves the kick wire from the weak drive and its enable.
 */
`timescale 1ns/1ps
`default_nettype none

module ekwdt_top #(
	parameter int unsigned TIMEOUT_CYC = ekwdt_pkg::TIMEOUT_CYC,
	parameter int unsigned PULSE_CYC   = ekwdt_pkg::PULSE_CYC
) (
	input  wire logic                           clk_sys,            // 20 MHz system clock
	input  wire logic                           rst,                // Async reset, active high
	input  wire logic                           power_good_lockout, // High while supply is too low
	input  wire logic                           kick_input,         // Resolved kick pin level
	output var  ekwdt_pkg::ekwdt_kick_pin_type  kick_pin,           // Weak drive and enable
	output var  logic                           fault_pulse_n       // Fault output, active low
);
	import ekwdt_pkg::*;

	localparam logic [CNT_W-1:0] TIMEOUT_LAST = CNT_W'(TIMEOUT_CYC - 1);
	localparam logic [CNT_W-1:0] PULSE_LAST   = CNT_W'(PULSE_CYC - 1);
	localparam logic [CNT_W-1:0] DRIVE_HI_AT  = CNT_W'(TIMEOUT_CYC - TIMEOUT_CYC / DRIVE_HI_DIV);

	ekwdt_state_type  state_reg;
	ekwdt_state_type  state_next;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic [CNT_W-1:0] pcnt_reg;
	logic [CNT_W-1:0] pcnt_next;
	logic             kick_prev_reg;
	logic             kick_edge;

	// One sample of history is enough: a single-cycle level is an edge
	assign kick_edge = (kick_input != kick_prev_reg);

	// Shared decode: the state holds across this edge, so its counter may advance
	function automatic logic stays_in(
		input ekwdt_state_type cur, // Present state
		input ekwdt_state_type nxt, // Next state
		input ekwdt_state_type st   // State asked about
	);
		return (cur == st) && (nxt == st);
	endfunction

	// Next state; lockout overrides everything
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_LOCK: begin
				if (!power_good_lockout) begin
					state_next = ST_PULSE;
				end
			end
			ST_PULSE: begin
				if (pcnt_reg == PULSE_LAST) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!kick_edge && cnt_reg == TIMEOUT_LAST) begin
					state_next = ST_PULSE;
				end
			end
			default: begin
				state_next = ST_LOCK;
			end
		endcase
		if (power_good_lockout) begin
			state_next = ST_LOCK;
		end
	end

	// Timeout counter; an edge wins over expiry in the same cycle
	always_comb begin
		cnt_next = '0;
		if (stays_in(state_reg, state_next, ST_RUN)) begin
			if (kick_edge) begin
				cnt_next = '0;
			end else begin
				cnt_next = cnt_reg + CNT_W'(1);
			end
		end
	end

	// Pulse counter, only runs inside a fault pulse
	always_comb begin
		pcnt_next = '0;
		if (stays_in(state_reg, state_next, ST_PULSE)) begin
			pcnt_next = pcnt_reg + CNT_W'(1);
		end
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= ST_LOCK;
		end else begin
			state_reg <= state_next;
		end
	end

	// Counters; timeout counter held at zero outside normal timing
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_reg  <= '0;
			pcnt_reg <= '0;
		end else begin
			cnt_reg  <= cnt_next;
			pcnt_reg <= pcnt_next;
		end
	end

	// Kick history for edge detection
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			kick_prev_reg <= DRIVE_RST;
		end else begin
			kick_prev_reg <= kick_input;
		end
	end

	// Fault output registered from next state so it moves with the state
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			fault_pulse_n <= FAULT_N_RST;
		end else begin
			fault_pulse_n <= (state_next == ST_RUN);
		end
	end

	// Weak driver: a floating pin follows it and so sees an edge at 7/8
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			kick_pin.drive <= DRIVE_RST;
			kick_pin.oe_n  <= OE_N_RST;
		end else begin
			kick_pin.drive <= (state_next == ST_RUN) && (cnt_next >= DRIVE_HI_AT);
			kick_pin.oe_n  <= 1'b0;
		end
	end

	// Checks of the design's own state, counters and outputs
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence release_then_count_s;
		(cnt_reg == '0) ##1 (cnt_reg == CNT_W'(1));
	endsequence

	sequence lockout_low_s;
		!fault_pulse_n [*8];
	endsequence

	kick_clear_a: assert property ((state_reg == ST_RUN && state_next == ST_RUN && kick_edge) |=> cnt_reg == '0)
		else $error("kick edge did not clear the timeout counter");

	timeout_fault_a: assert property ((state_reg == ST_RUN && !kick_edge && !power_good_lockout
		&& cnt_reg == TIMEOUT_LAST) |=> !fault_pulse_n && state_reg == ST_PULSE)
		else $error("timeout did not start a fault pulse");

	timeout_length_a: assert property (($fell(fault_pulse_n) && !$past(power_good_lockout))
		|-> $past(cnt_reg) == TIMEOUT_LAST)
		else $error("fault pulse began at the wrong count");

	pulse_length_a: assert property ($rose(fault_pulse_n) |-> $past(pcnt_reg) == PULSE_LAST
		&& $past(state_reg) == ST_PULSE)
		else $error("fault pulse length wrong");

	lockout_hold_a: assert property (power_good_lockout |=> !fault_pulse_n && state_reg == ST_LOCK)
		else $error("fault output high during lockout");

	release_pulse_a: assert property ($fell(power_good_lockout) |-> lockout_low_s)
		else $error("fault released too soon after lockout");

	float_service_a: assert property ((state_reg == ST_RUN && state_next == ST_RUN && kick_pin.drive
		&& kick_input == kick_pin.drive && !kick_prev_reg) |=> cnt_reg == '0)
		else $error("internal service edge did not clear the counter");

	pulse_cleared_a: assert property ((state_reg != ST_RUN) |-> cnt_reg == '0)
		else $error("timeout counter moved during fault");

	// Kick and lockout are judged in the release cycle itself, the one that sets the first count
	release_count_a: assert property (($rose(fault_pulse_n) && !kick_edge && !power_good_lockout)
		|-> release_then_count_s)
		else $error("counter did not start at release");

	drive_phase_a: assert property ((state_reg == ST_RUN) |-> kick_pin.drive == (cnt_reg >= DRIVE_HI_AT))
		else $error("weak driver phase wrong");

	// Counter ranges, the weak driver between timing phases and one-cycle kicks
	idle_drive_low_a: assert property ((state_reg != ST_RUN) |-> !kick_pin.drive)
		else $error("weak driver high outside normal timing");

	weak_enable_a: assert property (1'b1 |=> !kick_pin.oe_n)
		else $error("weak driver not enabled after reset");

	cnt_bound_a: assert property (cnt_reg <= TIMEOUT_LAST)
		else $error("timeout counter ran past the period");

	pcnt_bound_a: assert property (pcnt_reg <= PULSE_LAST)
		else $error("pulse counter ran past the pulse period");

	short_kick_a: assert property ((state_reg == ST_RUN && state_next == ST_RUN && $changed(kick_input))
		|=> cnt_reg == '0)
		else $error("one-cycle kick level missed");

endmodule

`default_nettype wire

// *** sim/ekwdt_host_model.sv ***
/*
 * Host side of the kick wire: drives it strongly or lets it float.
 * Assumes the bench changes host_level only just after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ekwdt_host_model (
	input  wire logic                          clk_sys,    // System clock
	input  wire logic                          host_en,    // Host drives the wire
	input  wire logic                          host_level, // Host drive level
	input  wire ekwdt_pkg::ekwdt_kick_pin_type kick_pin,   // Weak drive from device
	output wire logic                          kick_input  // Resolved wire level
);
	import ekwdt_pkg::*;
	logic last_reg = 1'b0; // Last wire level
	// Remember the wire so an undriven wire never holds its old value
	always @(posedge clk_sys) begin
		last_reg <= kick_input;
	end
	// Strong host beats the weak drive; each host level lasts whole cycles
	assign kick_input = host_en ? host_level : (!kick_pin.oe_n ? kick_pin.drive : ~last_reg);
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
/*
 * Self-checking bench for the watchdog with shortened counts.
 * Assumes the host model resolves the kick wire.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ekwdt_pkg::*;
	localparam int T = 64;
	localparam int P = 16;
	typedef struct { int gap; int reps; logic low; } ekwdt_row_type;
	logic               clk_sys = 1'b0;
	logic               rst = 1'b1;
	logic               power_good_lockout = 1'b1;
	logic               host_en = 1'b1;
	logic               host_level = 1'b0;
	logic               kick_input;
	ekwdt_kick_pin_type kick_pin;
	logic               fault_pulse_n;
	logic               low_seen = 1'b0;
	logic               hi_seen;
	int                 bad_count = 0;
	int                 n_compared = 0;
	int                 n;
	// Kick spacing rows, back to back so each gap is exact: every cycle, inside, outside
	ekwdt_row_type      rows [3] = '{'{1, 200, 1'b0}, '{T-1, 4, 1'b0}, '{T+4, 1, 1'b1}};
	ekwdt_top #(.TIMEOUT_CYC(T), .PULSE_CYC(P)) ekwdt_top_inst (.clk_sys(clk_sys), .rst(rst),
		.power_good_lockout(power_good_lockout), .kick_input(kick_input), .kick_pin(kick_pin),
		.fault_pulse_n(fault_pulse_n));
	ekwdt_host_model ekwdt_host_model_inst (.clk_sys(clk_sys), .host_en(host_en),
		.host_level(host_level), .kick_pin(kick_pin), .kick_input(kick_input));
	// 20 MHz clock
	initial begin
		forever #25 clk_sys = ~clk_sys;
	end
	// Each step notes a fault cycle; one process owns low_seen
	task automatic step();
		@(posedge clk_sys);
		#5;
		if (fault_pulse_n === 1'b0) low_seen = 1'b1;
	endtask
	task automatic check_cnt(input int exp, input int got);
		n_compared++;
		if (exp != got) begin
			bad_count++;
			$display("Error at %0t: expected %0h got %0h", $time, exp, got);
		end
	endtask
	task automatic check_bit(input logic exp, input logic got);
		n_compared++;
		if (exp !== got) begin
			bad_count++;
			$display("Error at %0t: expected %0h got %0h", $time, exp, got);
		end
	endtask
	// Cycles the fault output stays at lvl; tog kicks early on to prove they are ignored
	task automatic span(input logic lvl, input bit tog);
		n = 0;
		while (fault_pulse_n === lvl && n < 1000) begin
			step();
			n++;
			if (tog && n < P / 2) host_level = ~host_level;
		end
	endtask
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Hang guard, well beyond the thousand or so cycles needed
	initial begin
		#500000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		repeat (6) step();
		rst = 1'b0;
		repeat (4) begin
			step();
			check_bit(1'b0, fault_pulse_n);
		end
		check_bit(1'b0, kick_pin.oe_n);
		power_good_lockout = 1'b0;
		step();
		span(1'b0, 1'b0);
		check_cnt(P, n);
		span(1'b1, 1'b0);
		check_cnt(T, n);
		span(1'b0, 1'b1);
		check_cnt(P, n);
		span(1'b1, 1'b0);
		check_cnt(T, n);
		span(1'b0, 1'b0);
		foreach (rows[i]) begin
			low_seen = 1'b0;
			repeat (rows[i].reps) begin
				repeat (rows[i].gap) step();
				host_level = ~host_level;
			end
			check_bit(rows[i].low, low_seen);
			if (fault_pulse_n === 1'b0) span(1'b0, 1'b0);
		end
		// Floating wire: weak drive must keep servicing the counter
		host_en = 1'b0;
		low_seen = 1'b0;
		hi_seen = 1'b0;
		repeat (4 * T) begin
			step();
			if (kick_pin.drive === 1'b1) hi_seen = 1'b1;
		end
		check_bit(1'b0, low_seen);
		check_bit(1'b1, hi_seen);
		// Reset in mid-run behaves as a lockout
		host_en = 1'b1;
		rst = 1'b1;
		step();
		check_bit(1'b0, fault_pulse_n);
		check_bit(1'b1, kick_pin.oe_n);
		rst = 1'b0;
		step();
		span(1'b0, 1'b0);
		check_cnt(P, n);
		tally_and_finish();
	end
endmodule
`default_nettype wire
